// ==== design/ufb_uart.sv ====
// serial port core: registers, baud generator, transmitter, receiver, fifos
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// generic fifo
module ufb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock, reset and enable
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == LAST) ? '0 : p + 1'b1;
  endfunction : nextPtr

  assign inReady  = cnt_q != FULL;
  assign outValid = cnt_q != '0;
  assign outData  = mem[rp_q];
  assign push     = ce & inValid & inReady;
  assign pop      = ce & outValid & outReady;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_q] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= nextPtr(wp_q);
      end
      if (pop)
      begin
        rp_q <= nextPtr(rp_q);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : ufb_fifo

// ==========================================================
// serial port top
module ufb_uart (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // special-function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWr,
  input  wire logic       sfrRd,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata_q,
  // usb-domain clock enable and interrupt enable
  input  wire logic       usbClkTick,
  input  wire logic       portIntEnable,
  output logic            serialIrq_q,
  // serial pins and transmit fifo ready
  input  wire logic       rxPin,
  output logic            txPin_q,
  output logic            txFifoReady_q
);
  ufb_pkg::ufb_state_t    txSt_q;
  ufb_pkg::ufb_state_t    rxSt_q;
  ufb_pkg::ufb_rx_entry_t rxHead;
  ufb_pkg::ufb_rx_entry_t rxNew;
  logic [7:0]  mode_q;
  logic [7:0]  baudCtl_q;
  logic [15:0] reload_q;
  logic        ovr_q, perr_q, ren_q, tbx_q, ti_q, ri_q;
  logic        wrCtl, wrMode, wrBaud, wrLo, wrHi, wrData, rdCtl, rdBaud, rdData;
  logic        run, srcTick, prescTick, halfTick;
  logic [5:0]  psCnt_q;
  logic [15:0] baudCnt_q;
  logic [3:0]  lenBits, nStop;
  logic        pe, xbe, hasX;
  logic [1:0]  ptype;
  logic        txValid, txLoad, txTick, txPh_q, tiSet, txInReady;
  logic [7:0]  txHead, txShift_q;
  logic [3:0]  txCnt_q;
  logic        txX_q;
  logic        rxS1_q, rxS2_q, rxPrev_q, rxPh_q, rxSample;
  logic [7:0]  rxShift_q;
  logic [3:0]  rxCnt_q;
  logic        rxX_q, stopOk_q, firstStop_q;
  logic        rxDone, rxGood, rxPush, rxInReady, rxValid, mcePass, parBad;

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = a == t;
  endfunction : hit

  function automatic logic parOf(input logic [7:0] d, input logic [3:0] n,
                                 input logic [1:0] t);
    logic [7:0] m;
    m = d & ~(ufb_pkg::ONES8 << n);
    case (t)
      ufb_pkg::PAR_ODD:  parOf = ~^m;
      ufb_pkg::PAR_EVEN: parOf = ^m;
      ufb_pkg::PAR_MARK: parOf = 1'b1;
      default:           parOf = 1'b0;
    endcase
  endfunction : parOf

  function automatic logic [5:0] divOf(input logic [1:0] ps);
    case (ps)
      ufb_pkg::PS_BY12: divOf = ufb_pkg::DIV12;
      ufb_pkg::PS_BY4:  divOf = ufb_pkg::DIV4;
      ufb_pkg::PS_BY48: divOf = ufb_pkg::DIV48;
      default:          divOf = ufb_pkg::DIV1;
    endcase
  endfunction : divOf

  // ==========================================================
  // register access
  assign wrCtl  = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_CTL);
  assign wrMode = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_MODE);
  assign wrBaud = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_BAUD_CTL);
  assign wrLo   = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_RELOAD_LO);
  assign wrHi   = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_RELOAD_HI);
  assign wrData = ce & sfrWr & hit(sfrAddr, ufb_pkg::ADDR_DATA);
  assign rdCtl  = ce & sfrRd & hit(sfrAddr, ufb_pkg::ADDR_CTL);
  assign rdBaud = ce & sfrRd & hit(sfrAddr, ufb_pkg::ADDR_BAUD_CTL);
  assign rdData = ce & sfrRd & hit(sfrAddr, ufb_pkg::ADDR_DATA);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_q    <= ufb_pkg::MODE_RESET;
      baudCtl_q <= ufb_pkg::BAUD_RESET;
      reload_q  <= ufb_pkg::RELOAD_RESET;
      ren_q     <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_REN];
      tbx_q     <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_TBX];
    end
    else
    begin
      if (wrMode)
        mode_q <= sfrWdata;
      if (wrBaud)
        baudCtl_q <= sfrWdata & ufb_pkg::BAUD_WMASK;
      if (wrLo)
        reload_q[7:0] <= sfrWdata;
      if (wrHi)
        reload_q[15:8] <= sfrWdata;
      if (wrCtl)
      begin
        ren_q <= sfrWdata[ufb_pkg::CTL_REN];
        tbx_q <= sfrWdata[ufb_pkg::CTL_TBX];
      end
    end
  end

  // sticky flags: hardware set wins over a software write
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ovr_q  <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_OVR];
      perr_q <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_PERR];
      ti_q   <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_TI];
      ri_q   <= ufb_pkg::CTL_RESET[ufb_pkg::CTL_RI];
    end
    else if (ce)
    begin
      ovr_q  <= (rxGood & ~rxInReady) |
                (wrCtl ? sfrWdata[ufb_pkg::CTL_OVR] : ovr_q);
      perr_q <= (rxPush & pe & parBad) |
                (wrCtl ? sfrWdata[ufb_pkg::CTL_PERR] : perr_q);
      ti_q   <= tiSet | (wrCtl ? sfrWdata[ufb_pkg::CTL_TI] : ti_q);
      ri_q   <= rxPush | (wrCtl ? (sfrWdata[ufb_pkg::CTL_RI] |
                (ri_q & rxValid)) : ri_q);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sfrRdata_q    <= 8'h00;
      serialIrq_q   <= 1'b0;
      txFifoReady_q <= 1'b0;
    end
    else if (ce)
    begin
      serialIrq_q   <= portIntEnable & (ti_q | ri_q);
      txFifoReady_q <= txInReady;
      if (sfrRd)
      begin
        case (sfrAddr)
          ufb_pkg::ADDR_CTL:       sfrRdata_q <= {ovr_q, perr_q, 1'b1, ren_q, tbx_q,
                                                  rxValid & rxHead.extra, ti_q, ri_q};
          ufb_pkg::ADDR_DATA:      sfrRdata_q <= rxValid ? rxHead.data : 8'h00;
          ufb_pkg::ADDR_MODE:      sfrRdata_q <= mode_q;
          ufb_pkg::ADDR_BAUD_CTL:  sfrRdata_q <= baudCtl_q;
          ufb_pkg::ADDR_RELOAD_LO: sfrRdata_q <= reload_q[7:0];
          ufb_pkg::ADDR_RELOAD_HI: sfrRdata_q <= reload_q[15:8];
          default:                 sfrRdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // frame format
  assign pe      = mode_q[ufb_pkg::MODE_PE];
  assign xbe     = mode_q[ufb_pkg::MODE_XBE];
  assign hasX    = pe | xbe;
  assign ptype   = mode_q[ufb_pkg::MODE_PT +: 2];
  assign lenBits = ufb_pkg::LEN_MIN + {2'b00, mode_q[ufb_pkg::MODE_LEN +: 2]};
  assign nStop   = (mode_q[ufb_pkg::MODE_SBL] && lenBits != ufb_pkg::LEN_MIN) ?
                   ufb_pkg::STOP_TWO : ufb_pkg::STOP_ONE;

  // ==========================================================
  // baud generator
  assign run       = baudCtl_q[ufb_pkg::BAUD_RUN];
  assign srcTick   = baudCtl_q[ufb_pkg::BAUD_CLK] ? usbClkTick : 1'b1;
  assign prescTick = ce & run & srcTick &
                     (psCnt_q == divOf(baudCtl_q[ufb_pkg::BAUD_PS +: 2]) - 6'h01);
  assign halfTick  = prescTick & (baudCnt_q == ufb_pkg::CNT_TOP);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      psCnt_q   <= 6'h00;
      baudCnt_q <= ufb_pkg::RELOAD_RESET;
    end
    else if (ce)
    begin
      if (!run)
      begin
        psCnt_q   <= 6'h00;
        baudCnt_q <= reload_q;
      end
      else
      begin
        if (prescTick)
          psCnt_q <= 6'h00;
        else if (srcTick)
          psCnt_q <= psCnt_q + 6'h01;
        if (prescTick)
          baudCnt_q <= halfTick ? reload_q : baudCnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // transmitter
  ufb_fifo #(.W(8), .D(ufb_pkg::TX_DEPTH)) txFifo (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .inValid  (wrData),
    .inData   (sfrWdata),
    .inReady  (txInReady),
    .outValid (txValid),
    .outData  (txHead),
    .outReady (txLoad)
  );

  assign txLoad = run & (txSt_q == ufb_pkg::ST_IDLE) & txValid;
  assign txTick = halfTick & txPh_q;
  assign tiSet  = txTick & ((txSt_q == ufb_pkg::ST_XBIT) |
                  (txSt_q == ufb_pkg::ST_DATA && txCnt_q == lenBits && !hasX));

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      txSt_q    <= ufb_pkg::ST_IDLE;
      txPin_q   <= 1'b1;
      txShift_q <= 8'h00;
      txCnt_q   <= 4'h0;
      txX_q     <= 1'b0;
      txPh_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (halfTick)
        txPh_q <= ~txPh_q;
      if (!run)
      begin
        txSt_q  <= ufb_pkg::ST_IDLE;
        txPin_q <= 1'b1;
      end
      else
      begin
        case (txSt_q)
          ufb_pkg::ST_IDLE:
          begin
            txPin_q <= 1'b1;
            if (txLoad)
            begin
              txShift_q <= txHead;
              txX_q     <= pe ? parOf(txHead, lenBits, ptype) : tbx_q;
              txPh_q    <= 1'b0;
              txPin_q   <= 1'b0;
              txSt_q    <= ufb_pkg::ST_START;
            end
          end
          ufb_pkg::ST_START:
          begin
            if (txTick)
            begin
              txPin_q   <= txShift_q[0];
              txShift_q <= txShift_q >> 1;
              txCnt_q   <= 4'h1;
              txSt_q    <= ufb_pkg::ST_DATA;
            end
          end
          ufb_pkg::ST_DATA:
          begin
            if (txTick)
            begin
              if (txCnt_q == lenBits)
              begin
                txPin_q <= hasX ? txX_q : 1'b1;
                txCnt_q <= 4'h1;
                txSt_q  <= hasX ? ufb_pkg::ST_XBIT : ufb_pkg::ST_STOP;
              end
              else
              begin
                txPin_q   <= txShift_q[0];
                txShift_q <= txShift_q >> 1;
                txCnt_q   <= txCnt_q + 4'h1;
              end
            end
          end
          ufb_pkg::ST_XBIT:
          begin
            if (txTick)
            begin
              txPin_q <= 1'b1;
              txSt_q  <= ufb_pkg::ST_STOP;
            end
          end
          ufb_pkg::ST_STOP:
          begin
            if (txTick)
            begin
              if (txCnt_q == nStop)
                txSt_q <= ufb_pkg::ST_IDLE;
              else
                txCnt_q <= txCnt_q + 4'h1;
            end
          end
          default:
            txSt_q <= ufb_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // receiver
  assign rxSample = halfTick & rxPh_q;
  assign rxDone   = rxSample & (rxSt_q == ufb_pkg::ST_STOP) & (rxCnt_q == nStop);
  assign mcePass  = ~mode_q[ufb_pkg::MODE_MCE] | pe | rxX_q;
  assign rxGood   = rxDone & stopOk_q & rxPrev_q & ren_q & mcePass;
  assign rxPush   = rxGood & rxInReady;
  assign rxNew.data  = rxShift_q >> (ufb_pkg::LEN_MAX - lenBits);
  assign rxNew.extra = xbe ? rxX_q :
                       ((rxCnt_q == ufb_pkg::STOP_ONE) ? rxPrev_q : firstStop_q);
  assign parBad   = parOf(rxNew.data, lenBits, ptype) != rxX_q;

  ufb_fifo #(.W(9), .D(ufb_pkg::RX_DEPTH)) rxFifo (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .inValid  (rxPush),
    .inData   (rxNew),
    .inReady  (rxInReady),
    .outValid (rxValid),
    .outData  (rxHead),
    .outReady (rdData)
  );

  // two-stage synchroniser, then the edge reference
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rxS1_q   <= 1'b1;
      rxS2_q   <= 1'b1;
      rxPrev_q <= 1'b1;
    end
    else if (ce)
    begin
      rxS1_q   <= rxPin;
      rxS2_q   <= rxS1_q;
      rxPrev_q <= rxS2_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rxSt_q      <= ufb_pkg::ST_IDLE;
      rxShift_q   <= 8'h00;
      rxCnt_q     <= 4'h0;
      rxX_q       <= 1'b0;
      rxPh_q      <= 1'b0;
      stopOk_q    <= 1'b0;
      firstStop_q <= 1'b0;
    end
    else if (ce)
    begin
      if (halfTick)
        rxPh_q <= ~rxPh_q;
      if (!run || !ren_q)
        rxSt_q <= ufb_pkg::ST_IDLE;
      else
      begin
        case (rxSt_q)
          ufb_pkg::ST_IDLE:
          begin
            if (rxPrev_q && !rxS2_q)
              rxSt_q <= ufb_pkg::ST_START;
          end
          ufb_pkg::ST_START:
          begin
            if (halfTick)
            begin
              rxPh_q <= 1'b0;
              rxCnt_q <= 4'h1;
              rxSt_q <= rxPrev_q ? ufb_pkg::ST_IDLE : ufb_pkg::ST_DATA;
            end
          end
          ufb_pkg::ST_DATA:
          begin
            if (rxSample)
            begin
              rxShift_q <= {rxPrev_q, rxShift_q[7:1]};
              if (rxCnt_q == lenBits)
              begin
                rxCnt_q  <= 4'h1;
                stopOk_q <= 1'b1;
                rxSt_q   <= hasX ? ufb_pkg::ST_XBIT : ufb_pkg::ST_STOP;
              end
              else
                rxCnt_q <= rxCnt_q + 4'h1;
            end
          end
          ufb_pkg::ST_XBIT:
          begin
            if (rxSample)
            begin
              rxX_q  <= rxPrev_q;
              rxSt_q <= ufb_pkg::ST_STOP;
            end
          end
          ufb_pkg::ST_STOP:
          begin
            if (rxSample)
            begin
              stopOk_q <= stopOk_q & rxPrev_q;
              if (rxCnt_q == ufb_pkg::STOP_ONE)
                firstStop_q <= rxPrev_q;
              if (rxCnt_q == nStop)
                rxSt_q <= ufb_pkg::ST_IDLE;
              else
                rxCnt_q <= rxCnt_q + 4'h1;
            end
          end
          default:
            rxSt_q <= ufb_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence txBegin;
    ce && txLoad;
  endsequence

  overrun_set_a: assert property (ce && rxGood && !rxInReady |=> ovr_q)
    else $error("overrun not flagged");
  overrun_sticky_a: assert property (ovr_q && !(wrCtl && !sfrWdata[7]) |=> ovr_q)
    else $error("overrun cleared by hardware");
  ctl_bit_one_a: assert property (rdCtl |=> sfrRdata_q[5])
    else $error("control bit 5 read zero");
  tx_done_stop_a: assert property (ce && tiSet |=> ti_q && txPin_q)
    else $error("transmit done not at stop bit");
  rx_done_hold_a: assert property (wrCtl && rxValid && ri_q |=> ri_q)
    else $error("receive done dropped with bytes left");
  reserved_zero_a: assert property (rdBaud |=> sfrRdata_q[5:2] == 4'h0)
    else $error("reserved baud bits nonzero");
  stop_idle_a: assert property (ce && !run |=> txSt_q == ufb_pkg::ST_IDLE &&
                                rxSt_q == ufb_pkg::ST_IDLE)
    else $error("port active while stopped");
  start_low_a: assert property (txBegin |=> !txPin_q ##1 !txPin_q)
    else $error("start bit not low");
  ren_gate_a: assert property (ce && !ren_q |=> rxSt_q == ufb_pkg::ST_IDLE && !rxPush)
    else $error("receiver active while disabled");
  rx_done_set_a: assert property (ce && rxPush |=> ri_q)
    else $error("receive done not set");
endmodule : ufb_uart
`default_nettype wire

// ==== inc/ufb_pkg.sv ====
// constants and types for the serial port with receive fifo and baud generator
`default_nettype none
package ufb_pkg;
  // ==========================================================
  // register addresses on the special-function bus
  localparam logic [7:0] ADDR_BAUD_CTL  = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h93;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h94;
  localparam logic [7:0] ADDR_CTL       = 8'h98;
  localparam logic [7:0] ADDR_DATA      = 8'h99;
  localparam logic [7:0] ADDR_MODE      = 8'h9A;
  // ==========================================================
  // reset values
  localparam logic [7:0]  CTL_RESET    = 8'h20;
  localparam logic [7:0]  MODE_RESET   = 8'h0C;
  localparam logic [7:0]  BAUD_RESET   = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  // ==========================================================
  // field positions
  localparam int CTL_OVR  = 7;
  localparam int CTL_PERR = 6;
  localparam int CTL_ONE  = 5;
  localparam int CTL_REN  = 4;
  localparam int CTL_TBX  = 3;
  localparam int CTL_RBX  = 2;
  localparam int CTL_TI   = 1;
  localparam int CTL_RI   = 0;
  localparam int MODE_MCE = 7;
  localparam int MODE_PT  = 5;
  localparam int MODE_PE  = 4;
  localparam int MODE_LEN = 2;
  localparam int MODE_XBE = 1;
  localparam int MODE_SBL = 0;
  localparam int BAUD_CLK = 7;
  localparam int BAUD_RUN = 6;
  localparam int BAUD_PS  = 0;
  localparam logic [7:0] BAUD_WMASK = 8'hC3;
  // ==========================================================
  // encodings and counts
  localparam logic [1:0]  PAR_ODD   = 2'h0;
  localparam logic [1:0]  PAR_EVEN  = 2'h1;
  localparam logic [1:0]  PAR_MARK  = 2'h2;
  localparam logic [1:0]  PS_BY12   = 2'h0;
  localparam logic [1:0]  PS_BY4    = 2'h1;
  localparam logic [1:0]  PS_BY48   = 2'h2;
  localparam logic [5:0]  DIV12     = 6'h0C;
  localparam logic [5:0]  DIV4      = 6'h04;
  localparam logic [5:0]  DIV48     = 6'h30;
  localparam logic [5:0]  DIV1      = 6'h01;
  localparam logic [3:0]  LEN_MIN   = 4'h5;
  localparam logic [3:0]  LEN_MAX   = 4'h8;
  localparam logic [3:0]  STOP_ONE  = 4'h1;
  localparam logic [3:0]  STOP_TWO  = 4'h2;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  localparam logic [7:0]  ONES8     = 8'hFF;
  localparam int          RX_DEPTH  = 3;
  localparam int          TX_DEPTH  = 16;
  // ==========================================================
  // types
  typedef struct packed {
    logic       extra;
    logic [7:0] data;
  } ufb_rx_entry_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_XBIT  = 3'h3,
    ST_STOP  = 3'h4
  } ufb_state_t;
endpackage : ufb_pkg
`default_nettype wire

// ==== sim/ufb_serial_node.sv ====
// remote serial node: drives the receive line, captures the transmit line
`timescale 1ns/1ps
`default_nettype none
module ufb_serial_node #(
  parameter int BIT_CYC = 16
) (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic txPin,
  output var  logic rxPin
);
  initial rxPin = 1'b1;
  // ==========================================================
  // one bit time on the line, driven just after an edge
  task automatic hold(input logic v);
    rxPin = v;
    repeat (BIT_CYC) @(posedge clk);
    #1;
  endtask : hold
  // start low, lsb first, optional extra as bit 8, stop, idle high
  task automatic send(input logic [8:0] d, input int n, input logic stopLvl);
    @(posedge clk);
    #1;
    hold(1'b0);
    for (int i = 0; i < n; i++)
      hold(d[i]);
    hold(stopLvl);
    hold(1'b1);
  endtask : send
  // sample each bit a quarter in, the start bit may run short by up to a half bit
  task automatic grab(input int n, output logic [8:0] v);
    v = '0;
    while (txPin !== 1'b0)
      @(negedge clk);
    repeat (BIT_CYC + BIT_CYC / 4) @(negedge clk);
    for (int i = 0; i < n; i++)
    begin
      v[i] = txPin;
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask : grab
endmodule : ufb_serial_node
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic       clk;
  logic       nrst;
  logic [7:0] sfrAddr;
  logic       sfrWr;
  logic       sfrRd;
  logic [7:0] sfrWdata;
  logic [7:0] sfrRdata_q;
  logic       portIntEnable;
  logic       serialIrq_q;
  logic       rxPin;
  logic       txPin_q;
  logic       txFifoReady_q;
  logic       usbClkTick;
  int         num_errors;
  int         comparisons;
  ufb_uart u_ufb_uart (.clk(clk), .nrst(nrst), .ce(1'b1), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata_q(sfrRdata_q), .usbClkTick(usbClkTick),
    .portIntEnable(portIntEnable), .serialIrq_q(serialIrq_q), .rxPin(rxPin),
    .txPin_q(txPin_q), .txFifoReady_q(txFifoReady_q));
  ufb_serial_node u_node (.clk(clk), .txPin(txPin_q), .rxPin(rxPin));
  // ==========================================================
  // register port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    @(posedge clk);
    #1 sfrWr = 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex,
                    input string nm);
    @(posedge clk);
    #1 sfrAddr = a;
    sfrRd = 1'b1;
    @(posedge clk);
    #1 sfrRd = 1'b0;
    `CHK(nm, ex, sfrRdata_q & m)
  endtask : rc
  // ==========================================================
  // scenarios
  task automatic test_regs();
    rc(ufb_pkg::ADDR_CTL, 8'hFF, 8'h20, "ctl");
    `CHK("tx fifo ready", 1'b1, txFifoReady_q)
    rc(ufb_pkg::ADDR_MODE, 8'hFF, 8'h0C, "mode");
    rc(ufb_pkg::ADDR_RELOAD_HI, 8'hFF, 8'h00, "reload hi");
    rc(8'h97, 8'hFF, 8'h00, "unmapped");
    wr(ufb_pkg::ADDR_BAUD_CTL, 8'h03);
    rc(ufb_pkg::ADDR_BAUD_CTL, 8'hFF, 8'h03, "baud");
    wr(ufb_pkg::ADDR_CTL, 8'h00);
    rc(ufb_pkg::ADDR_CTL, 8'hFF, 8'h20, "ctl bit5");
    wr(ufb_pkg::ADDR_RELOAD_LO, 8'hF8);
    wr(ufb_pkg::ADDR_RELOAD_HI, 8'hFF);
    rc(ufb_pkg::ADDR_RELOAD_LO, 8'hFF, 8'hF8, "reload lo");
  endtask : test_regs
  task automatic test_tx();
    logic [8:0] v;
    logic [3:0] par;
    par = 4'b0110;
    wr(ufb_pkg::ADDR_MODE, 8'h0E);
    wr(ufb_pkg::ADDR_CTL, 8'h18);
    wr(ufb_pkg::ADDR_DATA, 8'hA5);
    repeat (40) @(posedge clk);
    `CHK("idle line", 1'b1, txPin_q)
    fork
      u_node.grab(9, v);
      wr(ufb_pkg::ADDR_BAUD_CTL, 8'h43);
    join
    `CHK("frame", 9'h1A5, v)
    rc(ufb_pkg::ADDR_CTL, 8'h02, 8'h02, "tx done");
    `CHK("irq", 1'b1, serialIrq_q)
    for (int t = 0; t < 4; t++)
    begin
      wr(ufb_pkg::ADDR_MODE, 8'h1C | 8'(t << 5));
      fork
        u_node.grab(9, v);
        wr(ufb_pkg::ADDR_DATA, 8'h01);
      join
      `CHK("parity", par[t], v[8])
    end
  endtask : test_tx
  task automatic test_rx();
    wr(ufb_pkg::ADDR_MODE, 8'h0C);
    wr(ufb_pkg::ADDR_CTL, 8'h10);
    for (int i = 1; i <= 4; i++)
      u_node.send(9'(i * 17), 8, 1'b1);
    rc(ufb_pkg::ADDR_CTL, 8'h81, 8'h81, "ovr rx done");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'h11, "byte 1");
    wr(ufb_pkg::ADDR_CTL, 8'h90);
    rc(ufb_pkg::ADDR_CTL, 8'h81, 8'h81, "ri held");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'h22, "byte 2");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'h33, "byte 3");
    wr(ufb_pkg::ADDR_CTL, 8'h10);
    rc(ufb_pkg::ADDR_CTL, 8'h81, 8'h00, "flags clr");
    u_node.send(9'h055, 8, 1'b0);
    rc(ufb_pkg::ADDR_CTL, 8'h01, 8'h00, "bad stop");
    wr(ufb_pkg::ADDR_CTL, 8'h00);
    u_node.send(9'h066, 8, 1'b1);
    wr(ufb_pkg::ADDR_CTL, 8'h10);
    rc(ufb_pkg::ADDR_CTL, 8'h01, 8'h00, "disabled");
    wr(ufb_pkg::ADDR_MODE, 8'h00);
    u_node.send(9'h0FF, 5, 1'b1);
    rc(ufb_pkg::ADDR_CTL, 8'h05, 8'h05, "rbx stop");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'h1F, "5 bit");
    wr(ufb_pkg::ADDR_MODE, 8'h8E);
    wr(ufb_pkg::ADDR_CTL, 8'h10);
    u_node.send(9'h0AA, 9, 1'b1);
    rc(ufb_pkg::ADDR_CTL, 8'h01, 8'h00, "filtered");
    u_node.send(9'h1AB, 9, 1'b1);
    rc(ufb_pkg::ADDR_CTL, 8'h05, 8'h05, "address");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'hAB, "addr byte");
    wr(ufb_pkg::ADDR_MODE, 8'h1C);
    u_node.send(9'h101, 9, 1'b1);
    rc(ufb_pkg::ADDR_CTL, 8'h41, 8'h41, "parity err");
    rc(ufb_pkg::ADDR_DATA, 8'hFF, 8'h01, "par byte");
    wr(ufb_pkg::ADDR_MODE, 8'h0D);
    wr(ufb_pkg::ADDR_CTL, 8'h10);
    u_node.send(9'h1C3, 9, 1'b0);
    rc(ufb_pkg::ADDR_CTL, 8'h01, 8'h00, "two stops");
  endtask : test_rx
  task automatic test_baud();
    logic [8:0] v;
    wr(ufb_pkg::ADDR_BAUD_CTL, 8'h00);
    wr(ufb_pkg::ADDR_MODE, 8'h0C);
    wr(ufb_pkg::ADDR_RELOAD_LO, 8'hFE);
    wr(ufb_pkg::ADDR_DATA, 8'h5A);
    fork
      u_node.grab(8, v);
      wr(ufb_pkg::ADDR_BAUD_CTL, 8'h41);
    join
    `CHK("div4 frame", 9'h05A, v)
    wr(ufb_pkg::ADDR_BAUD_CTL, 8'h00);
    wr(ufb_pkg::ADDR_RELOAD_LO, 8'hFC);
    wr(ufb_pkg::ADDR_DATA, 8'hC3);
    fork
      u_node.grab(8, v);
      wr(ufb_pkg::ADDR_BAUD_CTL, 8'hC3);
    join
    `CHK("usb frame", 9'h0C3, v)
    wr(ufb_pkg::ADDR_BAUD_CTL, 8'h00);
    for (int i = 0; i < 16; i++)
      wr(ufb_pkg::ADDR_DATA, 8'(i));
    repeat (2) @(posedge clk);
    `CHK("tx fifo full", 1'b0, txFifoReady_q)
  endtask : test_baud
  // ==========================================================
  // verdict
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // usb-domain tick every second cycle
  initial
  begin
    usbClkTick = 1'b0;
    forever
    begin
      @(posedge clk);
      #1 usbClkTick = ~usbClkTick;
    end
  end
  initial
  begin
    nrst = 1'b0;
    sfrAddr = '0;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    sfrWdata = '0;
    portIntEnable = 1'b1;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    test_regs();
    test_tx();
    test_rx();
    test_baud();
    test_done();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
